// File: rtl/fwsr_pkg.sv
// Constants for the flash write-and-status host controller.
// Assumes a word-wide asynchronous parallel flash on the far side.
package fwsr_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_RDATA = 8'h10;
  // Status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_FAIL = 2;
  localparam int STAT_READY = 3;
  localparam int STAT_POLL = 4;
  localparam int STAT_TLIM = 5;
  localparam int STAT_EWIN = 6;
  // Flash status bit positions in the read word, and the sector address LSB
  localparam int BIT_POLL = 7;
  localparam int BIT_TOGGLE = 6;
  localparam int BIT_TLIM = 5;
  localparam int BIT_EWIN = 3;
  localparam int SECT_LSB = 12;
  // Command-cycle codes and unlock addresses
  localparam logic [16:0] UNLOCK_A1 = 17'h00555;
  localparam logic [16:0] UNLOCK_A2 = 17'h002AA;
  localparam logic [7:0] CODE_UNL1 = 8'hAA;
  localparam logic [7:0] CODE_UNL2 = 8'h55;
  localparam logic [7:0] CODE_RESET = 8'hF0;
  localparam logic [7:0] CODE_PROG = 8'hA0;
  localparam logic [7:0] CODE_ID = 8'h90;
  localparam logic [7:0] CODE_ERASE = 8'h80;
  localparam logic [7:0] CODE_CHIP = 8'h10;
  localparam logic [7:0] CODE_SECT = 8'h30;
  localparam logic [7:0] CODE_SUSP = 8'hB0;
  localparam logic [7:0] CODE_RESUME = 8'h30;
  // Bus cycle timing
  localparam int CLK_MHZ = 50;
  localparam int T_STROBE_NS = 60;
  localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_LEN = STROBE_CYC + 7;
  typedef enum logic [3:0] {
    CMD_READ, CMD_RESET, CMD_PROGRAM, CMD_CHIP_ERASE,
    CMD_SECTOR_ERASE, CMD_SUSPEND, CMD_RESUME, CMD_ID_READ
  } fwsr_cmd_t;
endpackage : fwsr_pkg

// File: rtl/fwsr_host.sv
// Host controller that drives an asynchronous parallel flash by its pins.
// Assumes software orders it over AXI4-Lite; flash pins are asynchronous.
`timescale 1ns/1ps

module fwsr_host
  import fwsr_pkg::*;
(
  input wire logic clk, // 50 MHz clock
  input wire logic reset_n, // Asynchronous reset
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic [fwsr_pkg::ADDR_W-1:0] flash_addr, // Flash address pins
  output logic [fwsr_pkg::DATA_W-1:0] flash_dq_out, // Flash data out
  output logic flash_dq_oe, // Flash data drive enable
  input wire logic [fwsr_pkg::DATA_W-1:0] flash_dq_in, // Flash data in
  output logic flash_ce_n, // Chip enable
  output logic flash_we_n, // Write enable
  output logic flash_oe_n, // Output enable
  output logic flash_reset_n, // Flash hardware reset
  input wire logic ready_busy_n // Flash ready/busy pin
);
  import fwsr_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_BUS, S_DEC} fwsr_state_t;
  typedef enum logic [1:0] {P_FIRST, P_SECOND, P_FINAL} fwsr_poll_t;

  fwsr_state_t st_q;
  fwsr_poll_t pstep_q;
  fwsr_cmd_t cmd_q;
  logic [2:0] idx_q;
  logic [3:0] cnt_q;
  logic poll_q, recheck_q, tg1_q, done_q, fail_q;
  logic [ADDR_W-1:0] addr_reg_q;
  logic [DATA_W-1:0] wdata_reg_q, rdata_reg_q, samp_q;
  logic [DATA_W-1:0] dq_s1_q, dq_s2_q;
  logic rb_s1_q, rb_s2_q;
  logic aw_hold_q, w_hold_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic start;
  logic [34:0] seq_w;
  logic cur_rd, cur_last;
  logic [ADDR_W-1:0] cur_a, tgt_addr;
  logic [DATA_W-1:0] cur_d;
  logic cyc_end;

  // ****************************************
  // Command sequence table
  // ****************************************
  function automatic logic [34:0] seq_f(fwsr_cmd_t c, logic [2:0] i, logic [16:0] arg_a, logic [15:0] arg_d);
    logic [16:0] a;
    logic [7:0] code;
    logic rd;
    logic last;
    logic [15:0] d;
    rd = 1'b0;
    last = 1'b0;
    code = (c == CMD_PROGRAM) ? CODE_PROG : (c == CMD_ID_READ) ? CODE_ID : CODE_ERASE;
    unique case (i)
      3'd0: {a, d} = {UNLOCK_A1, 8'h00, CODE_UNL1};
      3'd1: {a, d} = {UNLOCK_A2, 8'h00, CODE_UNL2};
      3'd2: {a, d} = {UNLOCK_A1, 8'h00, code};
      3'd3: {a, d} = {UNLOCK_A1, 8'h00, CODE_UNL1};
      3'd4: {a, d} = {UNLOCK_A2, 8'h00, CODE_UNL2};
      default: {a, d} = {UNLOCK_A1, 8'h00, CODE_CHIP};
    endcase
    if (c == CMD_READ || c == CMD_RESET || c == CMD_SUSPEND || c == CMD_RESUME) begin
      a = arg_a;
      rd = (c == CMD_READ);
      last = 1'b1;
      d = {8'h00, (c == CMD_SUSPEND) ? CODE_SUSP : (c == CMD_RESUME) ? CODE_RESUME : CODE_RESET};
    end else if (i == 3'd3 && c == CMD_PROGRAM) begin
      a = arg_a;
      d = arg_d;
      last = 1'b1;
    end else if (i == 3'd3 && c == CMD_ID_READ) begin
      a = arg_a;
      rd = 1'b1;
      last = 1'b1;
    end else if (i == 3'd5) begin
      last = 1'b1;
      if (c == CMD_SECTOR_ERASE) begin
        // sector address on high bits only
        a = {arg_a[ADDR_W-1:SECT_LSB], 12'h000};
        d = {8'h00, CODE_SECT};
      end
    end
    return {rd, last, a, d};
  endfunction : seq_f

  function automatic logic [31:0] merge_f(logic [31:0] old, logic [31:0] nw, logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (nw & m);
  endfunction : merge_f

  // poll at programmed or erased-sector address
  assign tgt_addr = (cmd_q == CMD_SECTOR_ERASE) ? {addr_reg_q[ADDR_W-1:SECT_LSB], 12'h000} : addr_reg_q;
  assign seq_w = seq_f(cmd_q, idx_q, addr_reg_q, wdata_reg_q);
  assign cur_rd = poll_q ? 1'b1 : seq_w[34];
  assign cur_last = poll_q ? 1'b0 : seq_w[33];
  assign cur_a = poll_q ? tgt_addr : seq_w[32:16];
  assign cur_d = seq_w[15:0];
  assign cyc_end = (st_q == S_BUS) && (cnt_q == 4'(CYC_LEN - 1));

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
    end else begin
      dq_s1_q <= flash_dq_in;
      dq_s2_q <= dq_s1_q;
      rb_s1_q <= ready_busy_n;
      rb_s2_q <= rb_s1_q;
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign start = aw_hold_q && w_hold_q && aw_addr_q == OFF_CTRL && w_strb_q[0] && st_q == S_IDLE;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      addr_reg_q <= 17'h00000;
      wdata_reg_q <= 16'h0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (aw_hold_q && w_hold_q) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_q > OFF_RDATA || aw_addr_q[1:0] != 2'h0) ? 2'h2 : 2'h0;
        if (aw_addr_q == OFF_ADDR)
          addr_reg_q <= 17'(merge_f(32'(addr_reg_q), w_data_q, w_strb_q));
        if (aw_addr_q == OFF_WDATA)
          wdata_reg_q <= 16'(merge_f(32'(wdata_reg_q), w_data_q, w_strb_q));
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
      unique case (s_axi_araddr)
        OFF_CTRL: s_axi_rdata <= {28'h0000000, cmd_q};
        OFF_ADDR: s_axi_rdata <= {15'h0000, addr_reg_q};
        OFF_WDATA: s_axi_rdata <= {16'h0000, wdata_reg_q};
        OFF_STATUS: begin
          s_axi_rdata[STAT_BUSY] <= (st_q != S_IDLE);
          s_axi_rdata[STAT_DONE] <= done_q;
          s_axi_rdata[STAT_FAIL] <= fail_q;
          s_axi_rdata[STAT_READY] <= rb_s2_q;
          s_axi_rdata[STAT_POLL] <= samp_q[BIT_POLL];
          s_axi_rdata[STAT_TLIM] <= samp_q[BIT_TLIM];
          s_axi_rdata[STAT_EWIN] <= samp_q[BIT_EWIN];
        end
        OFF_RDATA: s_axi_rdata <= {16'h0000, rdata_reg_q};
        default: s_axi_rresp <= 2'h2;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= S_IDLE;
      pstep_q <= P_FIRST;
      cmd_q <= CMD_READ;
      idx_q <= 3'd0;
      cnt_q <= 4'h0;
      poll_q <= 1'b0;
      recheck_q <= 1'b0;
      tg1_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      samp_q <= 16'h0000;
      rdata_reg_q <= 16'h0000;
    end else begin
      unique case (st_q)
        S_IDLE: if (start) begin
          cmd_q <= fwsr_cmd_t'(w_data_q[3:0]);
          idx_q <= 3'd0;
          cnt_q <= 4'h0;
          done_q <= 1'b0;
          fail_q <= 1'b0;
          st_q <= S_BUS;
        end
        S_BUS: begin
          cnt_q <= cnt_q + 4'h1;
          if (cyc_end) begin
            if (cur_rd)
              samp_q <= dq_s2_q;
            st_q <= S_DEC;
          end
        end
        S_DEC: begin
          cnt_q <= 4'h0;
          st_q <= S_BUS;
          if (poll_q) begin
            unique case (pstep_q)
              P_FIRST: begin
                tg1_q <= samp_q[BIT_TOGGLE];
                pstep_q <= P_SECOND;
              end
              P_SECOND: if (samp_q[BIT_TOGGLE] == tg1_q) begin
                // one more read for valid data
                pstep_q <= P_FINAL;
              end else if (recheck_q) begin
                // still toggling after error bit, reset
                fail_q <= 1'b1;
                poll_q <= 1'b0;
                cmd_q <= CMD_RESET;
                idx_q <= 3'd0;
              end else begin
                // restart check with two fresh reads
                recheck_q <= samp_q[BIT_TLIM];
                pstep_q <= P_FIRST;
              end
              P_FINAL: begin
                rdata_reg_q <= samp_q;
                poll_q <= 1'b0;
                done_q <= 1'b1;
                st_q <= S_IDLE;
              end
            endcase
          end else if (!cur_last) begin
            idx_q <= idx_q + 3'd1;
          end else if (cmd_q == CMD_PROGRAM || cmd_q == CMD_CHIP_ERASE || cmd_q == CMD_SECTOR_ERASE) begin
            poll_q <= 1'b1;
            recheck_q <= 1'b0;
            pstep_q <= P_FIRST;
          end else if (cmd_q == CMD_ID_READ) begin
            // leave identification mode by reset command
            rdata_reg_q <= samp_q;
            cmd_q <= CMD_RESET;
            idx_q <= 3'd0;
          end else begin
            if (cmd_q == CMD_READ)
              rdata_reg_q <= samp_q;
            done_q <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // Flash pins
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_dq_oe <= 1'b0;
      flash_addr <= 17'h00000;
      flash_dq_out <= 16'h0000;
      flash_reset_n <= 1'b0;
    end else begin
      flash_reset_n <= 1'b1;
      flash_ce_n <= !(st_q == S_BUS && cnt_q >= 4'h1 && cnt_q < 4'(CYC_LEN - 1));
      // writes use the write strobe only
      flash_we_n <= !(st_q == S_BUS && !cur_rd && cnt_q >= 4'h2 && cnt_q <= 4'(STROBE_CYC + 1));
      flash_oe_n <= !(st_q == S_BUS && cur_rd && cnt_q >= 4'h2 && cnt_q < 4'(CYC_LEN - 1));
      flash_dq_oe <= (st_q == S_BUS) && !cur_rd;
      flash_addr <= cur_a;
      flash_dq_out <= cur_d;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_toggle_seen;
    st_q == S_DEC && poll_q && pstep_q == P_SECOND && samp_q[BIT_TOGGLE] != tg1_q;
  endsequence
  sequence s_stable_seen;
    st_q == S_DEC && poll_q && pstep_q == P_SECOND && samp_q[BIT_TOGGLE] == tg1_q;
  endsequence

  a_no_rw_clash: assert property (!(!flash_we_n && !flash_oe_n))
    else $error("write and output strobes low together");
  a_fourth_is_read: assert property (st_q == S_BUS && !poll_q && cmd_q == CMD_ID_READ && idx_q == 3'd3 |-> cur_rd)
    else $error("fourth identification cycle is not a read");
  a_id_then_reset: assert property (st_q == S_DEC && !poll_q && cmd_q == CMD_ID_READ && cur_last
    |=> cmd_q == CMD_RESET && st_q == S_BUS ##1 (st_q == S_BUS)[*8] ##[1:4] st_q == S_IDLE)
    else $error("identification read not followed by reset command");
  a_stable_extra_read: assert property (s_stable_seen |=> pstep_q == P_FINAL ##[1:4] !flash_oe_n)
    else $error("no further read after toggle stopped");
  a_poll_address: assert property (st_q == S_BUS && poll_q && cnt_q == 4'h2 |-> flash_addr == tgt_addr)
    else $error("status polled at wrong address");
  a_fail_resets: assert property (s_toggle_seen and recheck_q |=> fail_q && cmd_q == CMD_RESET ##[1:12] !flash_we_n)
    else $error("repeated toggling did not issue reset");
  a_restart_check: assert property (s_toggle_seen and !recheck_q |=> pstep_q == P_FIRST && poll_q)
    else $error("toggle check not restarted from first read");
  a_done_only_stable: assert property ($rose(done_q) && $past(poll_q) |-> $past(pstep_q) == P_FINAL && !fail_q)
    else $error("poll finished without stable toggle");
endmodule : fwsr_host

// File: test/fwsr_flash_model.sv
// Behavioural parallel flash for the far side of the host controller.
// Assumes strobes from fwsr_host; the bench resolves the open-drain busy pin.
`timescale 1ns/1ps
module fwsr_flash_model
  import fwsr_pkg::*;
#(
  parameter int BUSY_NS = 2000,
  parameter logic [4:0] PROT_SECT = 5'h1F,
  parameter logic [15:0] MAKER_CODE = 16'h00C3 // Arbitrary value
) (
  input wire logic [16:0] addr, // Address pins
  input wire logic [15:0] dq_in, // Resolved data bus
  input wire logic ce_n, // Chip enable
  input wire logic we_n, // Write enable
  input wire logic oe_n, // Output enable
  input wire logic reset_n, // Hardware reset
  input wire logic force_fail, // Overrun the next operation
  output logic [15:0] dq_out, // Data towards host
  output logic rb_low // Pulls ready/busy low
);
  logic [15:0] mem [0:131071];
  logic [16:0] lat_a = '0;
  logic [15:0] val, held = 16'h0, target = 16'h0;
  logic tgl = 1'b0, ew = 1'b0, erasing = 1'b0;
  logic sect_erase = 1'b0;
  logic [4:0] ers_sect = 5'h00;
  int mode = 0;
  int step = 0;
  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
  end
  always @(negedge reset_n) begin
    mode = 0;
    step = 0;
  end
  always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n) lat_a = addr;
  always @(posedge we_n or posedge ce_n) if (we_n != ce_n) cycle(lat_a, dq_in);
  // low byte decode, suspend, resume, reset
  task automatic cycle(input logic [16:0] a, input logic [15:0] d);
    if (d[7:0] == CODE_SUSP && mode == 1 && sect_erase) mode = 4;
    else if (d[7:0] == CODE_RESUME && mode == 4 && step == 0) mode = 1;
    else if (d[7:0] == CODE_RESET && mode != 1) begin
      mode = 0;
      step = 0;
    end else if (mode == 1) step = 0;
    else if (step == 0) step = (a[10:0] == 11'h555 && d[7:0] == CODE_UNL1) ? 1 : 0;
    else if (step == 1 || step == 4) step = (a[10:0] == 11'h2AA && d[7:0] == CODE_UNL2) ? step + 1 : 0;
    else if (step == 2) begin
      step = d[7:0] == CODE_PROG ? 6 : d[7:0] == CODE_ERASE ? 3 : 0;
      if (d[7:0] == CODE_ID) mode = 2;
    end else if (step == 3) step = (d[7:0] == CODE_UNL1) ? 4 : 0;
    else begin
      if (step == 6) start(a, d, 0);
      else if (d[7:0] == CODE_CHIP) start(a, d, 1);
      else if (d[7:0] == CODE_SECT) start(a, d, 2);
      step = 0;
    end
  endtask : cycle
  // protected sectors untouched, overrun on demand
  task automatic start(input logic [16:0] a, input logic [15:0] d, input int kind);
    mode = 1;
    erasing = kind != 0;
    sect_erase = kind == 2;
    ers_sect = a[16:12];
    ew = 1'b0;
    target = d;
    fork
      begin
        #(BUSY_NS / 4) ew = 1'b1;
        #(BUSY_NS) wait (mode != 4);
        if (force_fail && mode == 1) mode = 3;
        else if (mode == 1) begin
          for (int i = 0; i < 131072; i++) begin
            if (i[16:12] != PROT_SECT && (kind == 1 || (kind == 0 && i == a) || (kind == 2 && i[16:12] == a[16:12])))
              mem[i] = kind != 0 ? 16'hFFFF : mem[i] & d;
          end
          mode = 0;
        end
      end
    join_none
  endtask : start
  always_comb begin
    if (mode == 2) val = addr[7:0] == 8'h02 ? {15'h0, addr[16:12] == PROT_SECT} : MAKER_CODE;
    else if (mode == 4) val = addr[16:12] == ers_sect ? 16'h0080 : mem[addr];
    else if (mode != 0) val = {8'h00, erasing ? 1'b0 : ~target[7], tgl, mode == 3, 1'b0, ew, 3'h0};
    else val = mem[addr];
  end
  // toggle on each read while working
  always @(negedge oe_n) if (mode == 1 || mode == 3) tgl = ~tgl;
  always @(posedge oe_n) held = val;
  assign dq_out = (!ce_n && !oe_n) ? val : ~held;
  assign rb_low = mode == 1 || mode == 3;
endmodule : fwsr_flash_model

// File: test/tb.sv
// Self-checking bench for the flash host controller over AXI4-Lite.
// Assumes the flash model on the pins and a pull-up on ready/busy.
`timescale 1ns/1ps
module tb;
  import fwsr_pkg::*;
  logic clk, reset_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, st, got;
  logic [1:0] bresp, rresp, resp;
  logic [16:0] f_addr;
  logic [15:0] f_out, m_out;
  logic f_oe, ce_n, we_n, oe_n, f_rst_n, rb_low, force_fail, saw_busy;
  int miscompares, checks;
  wire [15:0] dq_bus = f_oe ? f_out : m_out;
  fwsr_host uut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .flash_addr(f_addr), .flash_dq_out(f_out), .flash_dq_oe(f_oe), .flash_dq_in(dq_bus), .flash_ce_n(ce_n),
    .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_reset_n(f_rst_n), .ready_busy_n(!rb_low));
  fwsr_flash_model flash (.addr(f_addr), .dq_in(dq_bus), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .reset_n(f_rst_n),
    .force_fail(force_fail), .dq_out(m_out), .rb_low(rb_low));
  task automatic finish_test;
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic run(input fwsr_cmd_t c, input logic [16:0] a, input logic [15:0] d);
    int n;
    n = 0;
    st = 32'h0;
    saw_busy = 1'b0;
    wr(OFF_ADDR, {15'h0, a}, resp);
    wr(OFF_WDATA, {16'h0, d}, resp);
    wr(OFF_CTRL, {28'h0, c}, resp);
    while (st[STAT_DONE] !== 1'b1 && n < 400) begin
      rd(OFF_STATUS, st, resp);
      if (st[STAT_BUSY] && !st[STAT_READY]) saw_busy = 1'b1;
      n++;
    end
    chk(st[STAT_DONE], 1);
    rd(OFF_RDATA, got, resp);
  endtask : run
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #1_500_000;
    miscompares++;
    finish_test;
  end
  initial begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready, force_fail} = '0;
    {awaddr, araddr, wdata} = '0;
    miscompares = 0;
    checks = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(OFF_STATUS, st, resp);
    chk(st[3:0], 4'h8);
    chk(f_rst_n, 1);
    rd(8'h14, got, resp);
    chk({got[29:0], resp}, 32'h2);
    wr(8'h18, 32'h1, resp);
    chk(resp, 2'b10);
    run(CMD_PROGRAM, 17'h01234, 16'h12A5);
    chk(got, 32'h12A5);
    chk(flash.mem[17'h01234], 16'h12A5);
    chk(saw_busy, 1);
    chk(st[STAT_FAIL], 0);
    run(CMD_SUSPEND, 17'h01234, 16'h0);
    run(CMD_READ, 17'h01234, 16'h0);
    chk(got, 32'h12A5);
    run(CMD_PROGRAM, 17'h1F010, 16'h0000);
    chk(flash.mem[17'h1F010], 16'hFFFF);
    run(CMD_PROGRAM, 17'h02000, 16'h0F0F);
    run(CMD_SECTOR_ERASE, 17'h01234, 16'h0);
    chk(flash.mem[17'h01234], 16'hFFFF);
    chk(flash.mem[17'h02000], 16'h0F0F);
    run(CMD_ID_READ, 17'h1F002, 16'h0);
    chk(got, 32'h1);
    run(CMD_ID_READ, 17'h01002, 16'h0);
    chk(got, 32'h0);
    run(CMD_RESUME, 17'h02000, 16'h0);
    run(CMD_READ, 17'h02000, 16'h0);
    chk(got, 32'h0F0F);
    force_fail <= 1'b1;
    run(CMD_PROGRAM, 17'h00100, 16'h0055);
    chk(st[STAT_FAIL], 1);
    chk(st[STAT_TLIM], 1);
    force_fail <= 1'b0;
    run(CMD_READ, 17'h00100, 16'h0);
    chk(got, 32'hFFFF);
    run(CMD_CHIP_ERASE, 17'h0, 16'h0);
    run(CMD_READ, 17'h02000, 16'h0);
    chk(got, 32'hFFFF);
    finish_test;
  end
endmodule : tb
